//--- core/vrc_device.sv
`timescale 1ns/1ps
module vrc_device
  import vrc_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC
)(
  // clock and reset
  input  wire logic          MCLK,
  input  wire logic          SRST,
  // host link
  vrc_if.dev                 LINK,
  // memory array
  output logic [NB-1:0]      RAS_N,
  output logic [NB-1:0]      CAS_N,
  output logic [AW-1:0]      VADDR,
  output logic               TRANSFER_OUTPUT_ENABLE_N,
  // status
  output logic               PROGRAMMED,
  output logic               INIT_BUSY
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_REF  = 5'b00010,
    ST_ROW  = 5'b00100,
    ST_COL  = 5'b01000,
    ST_CAS  = 5'b10000
  } vrc_dst_e;

  typedef struct packed {
    vrc_dst_e      st;
    vrc_cfg_s      cfg;
    vrc_cfg_s      shadow;
    logic          prog;
    logic          ml_q;
    logic [22:0]   init_cnt;
    logic [10:0]   ref_cnt;
    logic          ref_pend;
    logic          lat;
    logic [1:0]    bank;
    logic [AW-1:0] row;
    logic [AW-1:0] col;
    logic [NB-1:0] ras;
    logic [NB-1:0] cas;
    logic [AW-1:0] vaddr;
    logic [3:0]    cnt;
    logic [1:0]    wcnt;
    logic          pacc;
    logic [2:0]    xcnt;
  } vrc_dev_s;

  vrc_dev_s      q;
  vrc_dev_s      next_q;
  vrc_cfg_s      pin_cfg;
  logic [NB-1:0] sel;
  logic [NB-1:0] pre_ok;
  logic [NB-1:0] pre_start;
  logic          init_busy;
  logic          start_req;
  logic          can_go;
  logic          tick;
  logic          grant;
  logic          fast;

  // ==================== per-bank precharge ====================
  // banks are timed apart so in bank modes 1 and 2 interleaved accesses do not wait on each other
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_pre
      vrc_precharge u_pre (
        .clk   (MCLK),
        .rst   (SRST),
        .start (pre_start[gi]),
        .ready (pre_ok[gi])
      );
    end
  endgenerate

  assign pre_start = q.ras & ~next_q.ras;
  assign init_busy = (q.init_cnt != 23'h0);

  // ==================== next state ====================
  always_comb begin
    next_q = q;
    grant  = 1'b0;
    fast   = 1'b0;
    tick   = 1'b0;
    pin_cfg.rah       = LINK.row[CFG_RAH_LSB +: 2];
    pin_cfg.asc       = LINK.row[CFG_ASC_LSB +: 2];
    pin_cfg.mode1     = LINK.row[CFG_MODE_BIT];
    pin_cfg.wait_st   = LINK.row[CFG_WAIT_LSB +: 2];
    pin_cfg.bank_mode = LINK.col[CFG_BANK_LSB +: 2];
    sel = vrc_ras_sel(q.cfg.bank_mode, q.lat ? q.bank : LINK.bank);
    start_req = q.lat | (q.cfg.mode1 & ~LINK.chip_select_n & ~LINK.addr_strobe_async_n & LINK.mode_load_n);
    // refresh, init, a pending transfer and a busy bank all hold the access off
    can_go = q.prog & ~init_busy & ~q.ref_pend & ~LINK.shift_load_request_adv
           & ((pre_ok & sel) == sel);

    // programming
    next_q.ml_q = LINK.mode_load_n;
    if (!LINK.mode_load_n) begin
      next_q.shadow = pin_cfg;
    end
    if (LINK.mode_load_n && !q.ml_q) begin
      next_q.cfg      = q.shadow;
      next_q.prog     = 1'b1;
      next_q.init_cnt = 23'(INIT_CYCLES);
    end else if (init_busy) begin
      next_q.init_cnt = q.init_cnt - 23'h1;
    end
    if (!LINK.mode_load_n && !LINK.chip_select_n && !LINK.access_request_n && !q.pacc) begin
      next_q.pacc        = 1'b1;
      next_q.cfg.wait_st = pin_cfg.wait_st;
      next_q.wcnt        = pin_cfg.wait_st;
    end else if (q.pacc && LINK.access_request_n) begin
      next_q.pacc = 1'b0;
    end
    if (q.wcnt != 2'h0) begin
      next_q.wcnt = q.wcnt - 2'h1;
    end

    // refresh request clock
    if (q.prog) begin
      if (q.ref_cnt == 11'h0) begin
        next_q.ref_cnt = 11'(REF_CYC - 1);
        tick           = 1'b1;
      end else begin
        next_q.ref_cnt = q.ref_cnt - 11'h1;
      end
    end

    // mode 0 address latch
    if (q.prog && LINK.mode_load_n && !q.cfg.mode1 && !LINK.chip_select_n && LINK.addr_latch_strobe) begin
      next_q.lat  = 1'b1;
      next_q.bank = LINK.bank;
      next_q.row  = LINK.row;
      next_q.col  = LINK.col;
    end

    unique case (q.st)
      ST_IDLE: begin
        next_q.vaddr = q.lat ? q.row : LINK.row;
        if (q.prog && q.ref_pend && !LINK.shift_load_request_adv && (&pre_ok)) begin
          grant        = 1'b1;
          next_q.st    = ST_REF;
          next_q.ras   = 4'hF;
          next_q.cnt   = 4'(TRAS_CYC - 1);
        end else if (start_req && can_go) begin
          fast        = ~q.lat;
          next_q.st   = ST_ROW;
          next_q.ras  = sel;
          next_q.cnt  = {2'h0, q.cfg.rah};
          next_q.wcnt = q.cfg.wait_st;
          next_q.lat  = 1'b0;
          if (!q.lat) begin
            next_q.col = LINK.col;
          end
        end
      end
      ST_REF: begin
        if (q.cnt == 4'h0) begin
          next_q.st  = ST_IDLE;
          next_q.ras = 4'h0;
        end else begin
          next_q.cnt = q.cnt - 4'h1;
        end
      end
      ST_ROW: begin
        if (q.cnt == 4'h0) begin
          next_q.st    = ST_COL;
          next_q.vaddr = q.col;
          next_q.cnt   = {2'h0, q.cfg.asc};
        end else begin
          next_q.cnt = q.cnt - 4'h1;
        end
      end
      ST_COL: begin
        if (q.cnt == 4'h0) begin
          next_q.st  = ST_CAS;
          next_q.cas = {{2{~LINK.byte_cas_enable_n[1]}}, {2{~LINK.byte_cas_enable_n[0]}}};
        end else begin
          next_q.cnt = q.cnt - 4'h1;
        end
      end
      ST_CAS: begin
        next_q.cas = {{2{~LINK.byte_cas_enable_n[1]}}, {2{~LINK.byte_cas_enable_n[0]}}};
        if (LINK.access_request_n) begin
          next_q.st  = ST_IDLE;
          next_q.ras = 4'h0;
          next_q.cas = 4'h0;
        end
      end
      default: begin
        next_q.st  = ST_IDLE;
        next_q.ras = 4'h0;
        next_q.cas = 4'h0;
      end
    endcase

    // a new tick beats the grant that clears the request
    next_q.ref_pend = tick | init_busy | (q.ref_pend & ~grant);

    // transfer cycle edge counter
    if (LINK.shift_load_n) begin
      next_q.xcnt = 3'h0;
    end else if (q.xcnt != 3'(XFER_EDGES)) begin
      next_q.xcnt = q.xcnt + 3'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.cfg      <= CFG_RESET;
      q.shadow   <= CFG_RESET;
      q.ml_q     <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==================== outputs ====================
  // the mode 1 strobe bypasses the flop so it follows the pin in the same cycle
  assign RAS_N = ~(q.ras | (fast ? sel : 4'h0));
  assign CAS_N = ~q.cas;
  assign VADDR = q.vaddr;
  assign TRANSFER_OUTPUT_ENABLE_N = LINK.shift_load_n | (q.xcnt == 3'(XFER_EDGES));
  assign LINK.transfer_ack_n = ~(((q.st == ST_CAS) | q.pacc) & (q.wcnt == 2'h0));
  assign PROGRAMMED = q.prog;
  assign INIT_BUSY  = init_busy;
endmodule

//--- core/vrc_pkg.sv
package vrc_pkg;
  // ==================== clock and timing ====================
  localparam int CLK_MHZ    = 100;
  localparam int INIT_MS    = 60;
  localparam int INIT_CYC   = INIT_MS * CLK_MHZ * 1000;
  localparam int REF_NS     = 15600;
  localparam int REF_CYC    = REF_NS * CLK_MHZ / 1000;
  localparam int TRAS_NS    = 80;
  localparam int TRAS_CYC   = (TRAS_NS * CLK_MHZ + 999) / 1000;
  localparam int TRP_NS     = 60;
  localparam int TRP_CYC    = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int XFER_EDGES = 4;
  localparam int ADV_CYC    = TRAS_CYC + TRP_CYC + 8;
  // ==================== widths ====================
  localparam int AW = 9;
  localparam int NB = 4;
  // ==================== programming word fields ====================
  localparam int CFG_RAH_LSB  = 0;
  localparam int CFG_ASC_LSB  = 2;
  localparam int CFG_MODE_BIT = 4;
  localparam int CFG_WAIT_LSB = 5;
  localparam int CFG_BANK_LSB = 0;
  localparam logic [1:0] BANKS_1 = 2'h0;
  localparam logic [1:0] BANKS_2 = 2'h1;
  typedef struct packed {
    logic [1:0] rah;
    logic [1:0] asc;
    logic       mode1;
    logic [1:0] wait_st;
    logic [1:0] bank_mode;
  } vrc_cfg_s;
  localparam vrc_cfg_s CFG_RESET = '0;
  typedef enum logic [1:0] {OP_PROG = 2'h0, OP_PROG_ACC = 2'h1, OP_ACCESS = 2'h2, OP_XFER = 2'h3} vrc_op_e;

  // ==================== bank to row strobe mapping ====================
  function automatic logic [NB-1:0] vrc_ras_sel(input logic [1:0] bm, input logic [1:0] b);
    case (bm)
      BANKS_1: return 4'hF;
      BANKS_2: return b[0] ? 4'hC : 4'h3;
      default: return 4'h1 << b;
    endcase
  endfunction
endpackage

//--- core/vrc_if.sv
`timescale 1ns/1ps
interface vrc_if;
  import vrc_pkg::*;
  logic          mode_load_n;
  logic          chip_select_n;
  logic          addr_latch_strobe;
  logic          addr_strobe_async_n;
  logic          access_request_n;
  logic [1:0]    bank;
  logic [AW-1:0] row;
  logic [AW-1:0] col;
  logic [1:0]    byte_cas_enable_n;
  logic          shift_load_request_adv;
  logic          shift_load_n;
  logic          transfer_ack_n;
  modport dev (
    input  mode_load_n, chip_select_n, addr_latch_strobe, addr_strobe_async_n, access_request_n,
    input  bank, row, col, byte_cas_enable_n, shift_load_request_adv, shift_load_n,
    output transfer_ack_n
  );
  modport host (
    output mode_load_n, chip_select_n, addr_latch_strobe, addr_strobe_async_n, access_request_n,
    output bank, row, col, byte_cas_enable_n, shift_load_request_adv, shift_load_n,
    input  transfer_ack_n
  );
endinterface

//--- core/vrc_precharge.sv
`timescale 1ns/1ps
module vrc_precharge
  import vrc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // strobe release and status
  input  wire logic start,
  output logic      ready
);
  typedef struct packed {
    logic [3:0] cnt;
  } vrc_pc_s;
  vrc_pc_s q;
  vrc_pc_s next_q;

  always_comb begin
    next_q = q;
    if (start) begin
      next_q.cnt = 4'(TRP_CYC);
    end else if (q.cnt != 4'h0) begin
      next_q.cnt = q.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ready = (q.cnt == 4'h0);
endmodule

//--- core/vrc_host.sv
`timescale 1ns/1ps
module vrc_host
  import vrc_pkg::*;
(
  // clock and reset
  input  wire logic          MCLK,
  input  wire logic          SRST,
  // command
  input  wire logic          CMD_VALID,
  output logic               CMD_READY,
  input  wire vrc_op_e       CMD_OP,
  input  wire logic          CMD_MODE1,
  input  wire logic [1:0]    CMD_BANK,
  input  wire logic [AW-1:0] CMD_ROW,
  input  wire logic [AW-1:0] CMD_COL,
  input  wire logic [1:0]    CMD_BYTE_EN,
  input  wire logic [3:0]    CMD_HOLD,
  output logic               DONE,
  // device link
  vrc_if.host                LINK
);
  typedef enum logic [6:0] {
    H_IDLE  = 7'b0000001,
    H_PROG  = 7'b0000010,
    H_LATCH = 7'b0000100,
    H_REQ   = 7'b0001000,
    H_ACK   = 7'b0010000,
    H_HOLD  = 7'b0100000,
    H_XFER  = 7'b1000000
  } vrc_hst_e;

  typedef struct packed {
    vrc_hst_e      st;
    logic          ml_n;
    logic          cs_n;
    logic          als;
    logic          ads_n;
    logic          access_request_n_n;
    logic [1:0]    bank;
    logic [AW-1:0] row;
    logic [AW-1:0] col;
    logic [1:0]    be_n;
    logic          adv;
    logic          sl_n;
    logic [5:0]    cnt;
    logic          done;
  } vrc_host_s;

  vrc_host_s q;
  vrc_host_s next_q;

  // ==================== next state ====================
  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    next_q.als  = 1'b0;
    unique case (q.st)
      H_IDLE: begin
        if (CMD_VALID) begin
          next_q.bank = CMD_BANK;
          next_q.row  = CMD_ROW;
          next_q.col  = CMD_COL;
          next_q.be_n = ~CMD_BYTE_EN;
          next_q.cnt  = {2'h0, CMD_HOLD};
          case (CMD_OP)
            OP_PROG: begin
              next_q.st   = H_PROG;
              next_q.ml_n = 1'b0;
            end
            OP_PROG_ACC: begin
              next_q.st     = H_ACK;
              next_q.ml_n   = 1'b0;
              next_q.cs_n   = 1'b0;
              next_q.access_request_n_n = 1'b0;
            end
            OP_ACCESS: begin
              next_q.cs_n = 1'b0;
              if (CMD_MODE1) begin
                // request tied to the async strobe
                next_q.st     = H_ACK;
                next_q.ads_n  = 1'b0;
                next_q.access_request_n_n = 1'b0;
              end else begin
                next_q.st  = H_LATCH;
                next_q.als = 1'b1;
              end
            end
            default: begin
              next_q.st  = H_XFER;
              next_q.adv = 1'b1;
              next_q.cnt = 6'(ADV_CYC);
            end
          endcase
        end
      end
      H_PROG: begin
        next_q.st   = H_IDLE;
        next_q.ml_n = 1'b1;
        next_q.done = 1'b1;
      end
      H_LATCH: begin
        next_q.st = H_REQ;
      end
      H_REQ: begin
        // one cycle after the latch so the request follows the row strobe edge
        next_q.st     = H_ACK;
        next_q.access_request_n_n = 1'b0;
      end
      H_ACK: begin
        if (!LINK.transfer_ack_n) begin
          next_q.st = H_HOLD;
        end
      end
      H_HOLD: begin
        if (q.cnt == 6'h0) begin
          next_q.st     = H_IDLE;
          next_q.ml_n   = 1'b1;
          next_q.cs_n   = 1'b1;
          next_q.ads_n  = 1'b1;
          next_q.access_request_n_n = 1'b1;
          next_q.done   = 1'b1;
        end else begin
          next_q.cnt = q.cnt - 6'h1;
        end
      end
      H_XFER: begin
        if (q.cnt != 6'h0) begin
          next_q.cnt = q.cnt - 6'h1;
          if (q.cnt == 6'h1) begin
            next_q.sl_n = 1'b0;
          end
        end else begin
          next_q.st   = H_IDLE;
          next_q.adv  = 1'b0;
          next_q.sl_n = 1'b1;
          next_q.done = 1'b1;
        end
      end
      default: begin
        next_q.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      q        <= '0;
      q.st     <= H_IDLE;
      q.ml_n   <= 1'b1;
      q.cs_n   <= 1'b1;
      q.ads_n  <= 1'b1;
      q.access_request_n_n <= 1'b1;
      q.be_n   <= 2'h3;
      q.sl_n   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==================== outputs ====================
  assign CMD_READY                = (q.st == H_IDLE);
  assign DONE                     = q.done;
  assign LINK.mode_load_n         = q.ml_n;
  assign LINK.chip_select_n       = q.cs_n;
  assign LINK.addr_latch_strobe   = q.als;
  assign LINK.addr_strobe_async_n = q.ads_n;
  assign LINK.access_request_n    = q.access_request_n_n;
  assign LINK.bank                = q.bank;
  assign LINK.row                 = q.row;
  assign LINK.col                 = q.col;
  assign LINK.byte_cas_enable_n   = q.be_n;
  assign LINK.shift_load_request_adv = q.adv;
  assign LINK.shift_load_n        = q.sl_n;
endmodule

//--- sim/vrc_chk.sv
`timescale 1ns/1ps
module vrc_chk
  import vrc_pkg::*;
(
  // clock and reset
  input logic          MCLK,
  input logic          SRST,
  // host link
  input logic          mode_load_n,
  input logic          chip_select_n,
  input logic          addr_latch_strobe,
  input logic          access_request_n,
  input logic [AW-1:0] col,
  input logic          shift_load_n,
  input logic          transfer_ack_n,
  // memory side
  input logic [NB-1:0] RAS_N,
  input logic [NB-1:0] CAS_N,
  input logic [AW-1:0] VADDR,
  input logic          TRANSFER_OUTPUT_ENABLE_N,
  input logic          PROGRAMMED,
  input logic          INIT_BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // ====================
  // transfer enable
  a_toe_on_load: assert property ($fell(shift_load_n) |-> !TRANSFER_OUTPUT_ENABLE_N)
    else $error("transfer enable missed the load");
  a_toe_idle_high: assert property (shift_load_n |-> TRANSFER_OUTPUT_ENABLE_N)
    else $error("transfer enable low without load");
  a_toe_max_four: assert property (not (!TRANSFER_OUTPUT_ENABLE_N [*5]))
    else $error("transfer enable low past fourth edge");
  // ====================
  // access strobes
  a_cas_after_ras: assert property ((CAS_N != 4'hF) |-> (RAS_N != 4'hF))
    else $error("column strobe without row strobe");
  a_cas_col_addr: assert property ((CAS_N != 4'hF && !access_request_n) |-> (VADDR == col))
    else $error("column strobe without column address");
  a_hold_while_req: assert property ((CAS_N != 4'hF && !access_request_n) |=> (CAS_N != 4'hF))
    else $error("column strobe dropped while requested");
  a_end_on_release: assert property ((CAS_N != 4'hF && access_request_n) |=> (CAS_N == 4'hF && transfer_ack_n))
    else $error("access not ended on release");
  // ack without cas is legal only in a programming access and the cycle after its release
  a_ack_in_cas: assert property ((!transfer_ack_n && CAS_N == 4'hF) |-> !$past(mode_load_n))
    else $error("ack outside column phase");
  a_mode0_start: assert property ((!chip_select_n && addr_latch_strobe && mode_load_n && PROGRAMMED && !INIT_BUSY)
    |-> ##[1:24] (RAS_N != 4'hF))
    else $error("latched access never started");
  a_precharge_min: assert property ($rose(RAS_N[0]) |=> RAS_N[0] [*5])
    else $error("row precharge too short");
  // ====================
  // programming and init
  a_prog_access: assert property ((!mode_load_n && !chip_select_n && !access_request_n) |-> ##[1:5] !transfer_ack_n)
    else $error("programming access not acknowledged");
  a_init_no_cas: assert property (INIT_BUSY |-> (CAS_N == 4'hF))
    else $error("access during init period");
  a_init_refresh: assert property ($rose(INIT_BUSY) |-> ##[0:20] (RAS_N == 4'h0))
    else $error("no refresh in init period");
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import vrc_pkg::*;
  localparam int INIT = 200;
  logic          mclk, srst, cmd_valid, cmd_ready, cmd_mode1, done;
  logic          toe_n, programmed, init_busy, m1_ok, ib_q, ads_q, m1_req, req_q;
  vrc_op_e       cmd_op;
  logic [1:0]    cmd_bank, cmd_be, bm;
  logic [3:0]    cmd_hold;
  logic [AW-1:0] cmd_row, cmd_col, vaddr, row_v, col_v;
  logic [NB-1:0] ras_n, cas_n, ras_v, cas_v, ras_q, cas_q;
  int            n_fail, n_tests, cyc, ras_cyc, cas_cyc, acc_cyc, ib_rise, ib_fall;
  int            toe_cnt, sl_cnt, adv_cnt, ref_cnt, cas_len, lat_diff, len6, req_cyc;
  vrc_if lk();
  vrc_device #(.INIT_CYCLES(INIT)) u_vrc_device (.MCLK(mclk), .SRST(srst), .LINK(lk), .RAS_N(ras_n),
    .CAS_N(cas_n), .VADDR(vaddr), .TRANSFER_OUTPUT_ENABLE_N(toe_n), .PROGRAMMED(programmed), .INIT_BUSY(init_busy));
  vrc_host u_vrc_host (.MCLK(mclk), .SRST(srst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_MODE1(cmd_mode1), .CMD_BANK(cmd_bank), .CMD_ROW(cmd_row), .CMD_COL(cmd_col), .CMD_BYTE_EN(cmd_be),
    .CMD_HOLD(cmd_hold), .DONE(done), .LINK(lk));
  vrc_chk u_vrc_chk (.MCLK(mclk), .SRST(srst), .mode_load_n(lk.mode_load_n), .chip_select_n(lk.chip_select_n),
    .addr_latch_strobe(lk.addr_latch_strobe), .access_request_n(lk.access_request_n), .col(lk.col),
    .shift_load_n(lk.shift_load_n), .transfer_ack_n(lk.transfer_ack_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .VADDR(vaddr), .TRANSFER_OUTPUT_ENABLE_N(toe_n), .PROGRAMMED(programmed), .INIT_BUSY(init_busy));
  // ====================
  // clock and monitor
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // sampled mid-cycle so registered and bypass paths have both settled
  always @(negedge mclk) begin
    if (ras_n != 4'hF && ras_q == 4'hF) begin
      ras_cyc = cyc;
      ras_v = ras_n;
      row_v = vaddr;
    end
    if (cas_n != 4'hF && cas_q == 4'hF) begin
      cas_cyc = cyc;
      cas_v = cas_n;
      col_v = vaddr;
      cas_len = 0;
    end
    if (cas_n != 4'hF) cas_len++;
    if (init_busy && !ib_q) ib_rise = cyc;
    if (!init_busy && ib_q) ib_fall = cyc;
    if (!toe_n) toe_cnt++;
    if (!lk.shift_load_n) sl_cnt++;
    if (lk.shift_load_request_adv) adv_cnt++;
    if (!lk.addr_strobe_async_n && ads_q) m1_ok = (ras_n != 4'hF);
    if (!lk.addr_strobe_async_n && ads_q) m1_req = lk.access_request_n;
    if (!lk.access_request_n && req_q) req_cyc = cyc;
    if (ras_n == 4'h0 && ras_q != 4'h0 && cas_n == 4'hF && !init_busy) ref_cnt++;
    ras_q = ras_n;
    cas_q = cas_n;
    ib_q = init_busy;
    ads_q = lk.addr_strobe_async_n;
    req_q = lk.access_request_n;
  end
  // ====================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmd(input vrc_op_e op, input logic m1, input logic [1:0] b, input logic [AW-1:0] r, c,
                     input logic [1:0] be);
    int k;
    @(negedge mclk);
    cmd_op = op;
    cmd_mode1 = m1;
    cmd_bank = b;
    cmd_row = r;
    cmd_col = c;
    cmd_be = be;
    cmd_valid = 1'b1;
    @(negedge mclk);
    acc_cyc = cyc;
    cmd_valid = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge mclk);
    chk("done", 1, done);
  endtask
  function automatic logic [3:0] exp_ras(input logic [1:0] m, input logic [1:0] b);
    if (m == 2'h0) return 4'h0;
    if (m == 2'h1) return b[0] ? 4'h3 : 4'hC;
    return ~(4'h1 << b);
  endfunction
  task automatic acc(input logic m1, input logic [1:0] b, input logic [1:0] be);
    cmd(OP_ACCESS, m1, b, 9'h0A5, 9'h15A, be);
    chk("ras", exp_ras(bm, b), ras_v);
    chk("cas", {{2{~be[1]}}, {2{~be[0]}}}, cas_v);
    chk("col", 9'h15A, col_v);
    if (!m1) chk("row", 9'h0A5, row_v);
    if (!m1) chk("ras to cas", 5, cas_cyc - ras_cyc);
  endtask
  // ====================
  // main sequence
  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_PROG;
    cmd_mode1 = 1'b0;
    cmd_bank = 2'h0;
    cmd_row = '0;
    cmd_col = '0;
    cmd_be = 2'h0;
    cmd_hold = 4'h1;
    ras_q = 4'hF;
    cas_q = 4'hF;
    ib_q = 1'b0;
    ads_q = 1'b1;
    req_q = 1'b1;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    chk("programmed", 0, programmed);
    chk("ras idle", 4'hF, ras_n);
    chk("toe idle", 1, toe_n);
    $display("test reset done");
    // row word: hold 2 cycles, setup 3 cycles, no wait states
    for (int i = 0; i < 3; i++) begin
      bm = i[1:0];
      cmd(i == 1 ? OP_PROG_ACC : OP_PROG, 1'b0, 2'h0, {4'h0, i == 1, 4'h9}, {7'h0, bm}, 2'h0);
      // the programmed flag follows the release of mode load by one edge
      @(negedge mclk);
      chk("programmed", 1, programmed);
      acc(i == 1, 2'h1, 2'h3);
      chk("init len", INIT, ib_fall - ib_rise);
      chk("init wait", 1, cas_cyc >= ib_rise + INIT);
      // another bank, so in bank modes 1 and 2 its precharge does not delay the strobe
      acc(i == 1, 2'h2, 2'h2);
      if (i == 1) chk("async ras", 1, m1_ok);
      if (i == 1) chk("req tied", 0, m1_req);
      $display("test bank mode %0d done", i);
    end
    for (int b = 0; b < 4; b++) begin
      acc(1'b0, b[1:0], b[0] ? 2'h2 : 2'h1);
      chk("req after ras", 1, req_cyc >= ras_cyc);
      lat_diff = ras_cyc - acc_cyc;
    end
    acc(1'b0, 2'h3, 2'h3);
    chk("same bank delay", 1, ras_cyc - acc_cyc > lat_diff);
    cmd_hold = 4'h6;
    acc(1'b0, 2'h0, 2'h3);
    len6 = cas_len;
    cmd_hold = 4'h1;
    acc(1'b0, 2'h1, 2'h3);
    chk("cas hold", 5, len6 - cas_len);
    $display("test banks done");
    toe_cnt = 0;
    sl_cnt = 0;
    adv_cnt = 0;
    cmd(OP_XFER, 1'b0, 2'h0, 9'h000, 9'h000, 2'h0);
    chk("toe len", sl_cnt, toe_cnt);
    chk("load seen", 1, sl_cnt > 0 && sl_cnt <= 4);
    chk("adv lead", 1, adv_cnt >= ADV_CYC);
    $display("test transfer done");
    ref_cnt = 0;
    repeat (REF_CYC + 100) @(negedge mclk);
    chk("refresh", 1, ref_cnt > 0);
    $display("test refresh done");
    stop_test();
  end
  // the tests need about 2500 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
endmodule
